/* uart_rx_defines.vh */
// register map, field positions, reset values and timing counts of the receive block
`ifndef UART_RX_DEFINES_VH
`define UART_RX_DEFINES_VH
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define ADDR_RSC        8'h00
`define ADDR_HOLD       8'h04
`define ADDR_DIV        8'h08
`define ADDR_CFG        8'h0C
`define ADDR_IRQ_STAT   8'h10
`define ADDR_IRQ_MASK   8'h14
// ---------------------------------------------------------------
// receive_status_control fields
// ---------------------------------------------------------------
`define RSC_ON          7
`define RSC_NINE        6
`define RSC_ONESHOT     5
`define RSC_CONT        4
`define RSC_ADDR        3
`define RSC_FRAME       2
`define RSC_OVER        1
`define RSC_BIT9        0
`define RSC_RESET       8'h00
// ---------------------------------------------------------------
// config fields and interrupt bits
// ---------------------------------------------------------------
`define CFG_HIGH        0
`define CFG_WIDE        1
`define CFG_SYNC        2
`define CFG_RESET       3'h0
`define DIV_RESET       16'h0000
`define IRQ_READY       0
`define IRQ_FRAME       1
`define IRQ_OVER        2
`define IRQ_RESET       3'h0
// ---------------------------------------------------------------
// bit time multipliers as shift counts
// ---------------------------------------------------------------
`define SHIFT_X4        5'h02
`define SHIFT_X16       5'h04
`define SHIFT_X64       5'h06
`endif

/* uart_receive_control.v */
// receive control, status and receiver core of the serial port, with ahb-lite register access
// Function
// - port off clears and holds receiver reset
// - ninth-bit select picks 9- or 8-bit characters
// - one-shot sync receive, self-clearing; async ignores
// - continuous receive runs until cleared; overrides one-shot
// - address filter keeps only ninth-bit-set characters in 9-bit async mode
// - frame flag follows the buffered head character
// - overflow sets flag; clearing continuous receive clears
// - ninth bit readable; firmware interprets it
// - sync wide mode matches async high wide divisor
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_defines.vh"
module uart_receive_control (
    // clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // serial pins
    input  wire        rx_pin,
    output wire        sync_clk_out,
    output wire        sync_clk_oe,
    // interrupt
    output wire        irq
);
    // ---------------------------------------------------------------
    // state encoding
    // ---------------------------------------------------------------
    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_START = 2'd1;
    localparam [1:0] ST_DATA  = 2'd2;
    localparam [1:0] ST_STOP  = 2'd3;

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    reg  [7:0]  ctrl_reg;       // writable bits 7:3 only
    reg  [15:0] div_reg;        // baud_divisor_value
    reg  [2:0]  cfg_reg;        // high speed, wide, sync
    reg  [2:0]  irq_stat_reg;   // sticky events
    reg  [2:0]  irq_mask_reg;   // enables
    reg  [7:0]  hold_reg;       // receive_holding_byte
    reg         hold_bit9_reg;  // ninth bit of head
    reg         hold_frame_fault_flag_reg;  // frame fault of head
    reg         hold_full_reg;  // head is valid
    reg         over_reg;       // overflow_fault_flag
    reg         wr_pend_reg;    // write data phase pending
    reg  [7:0]  wr_addr_reg;    // latched write address
    reg  [1:0]  state_reg;      // receiver state
    reg  [22:0] timer_reg;      // cycles within a bit
    reg  [3:0]  bitcnt_reg;     // data bits taken
    reg  [8:0]  shift_reg;      // incoming bits, lsb first
    reg  [2:0]  sync_reg;       // pin synchroniser
    reg         rx_level_reg;   // filtered line level

    // ---------------------------------------------------------------
    // decoded controls
    // ---------------------------------------------------------------
    wire port_on   = ctrl_reg[`RSC_ON];
    wire nine      = ctrl_reg[`RSC_NINE];
    wire oneshot   = ctrl_reg[`RSC_ONESHOT];
    wire cont      = ctrl_reg[`RSC_CONT];
    wire addr_filt = ctrl_reg[`RSC_ADDR];
    wire sync_mode = cfg_reg[`CFG_SYNC];
    // async needs continuous receive; sync takes either, continuous first
    wire rx_run    = port_on & ~over_reg & (cont | (sync_mode & oneshot));

    // ---------------------------------------------------------------
    // bit length from divisor and speed selects
    // ---------------------------------------------------------------
    // sync uses the fast wide relation whenever wide is selected
    reg  [4:0]  mult_shift;
    always @* begin
        if ((cfg_reg[`CFG_HIGH] & cfg_reg[`CFG_WIDE]) | (sync_mode & cfg_reg[`CFG_WIDE])) begin
            mult_shift = `SHIFT_X4;
        end else if (cfg_reg[`CFG_HIGH] | cfg_reg[`CFG_WIDE]) begin
            mult_shift = `SHIFT_X16;
        end else begin
            mult_shift = `SHIFT_X64;
        end
    end
    wire [22:0] bit_len  = {7'h00, div_reg} + 23'h000001 << mult_shift;
    wire [22:0] half_len = {1'b0, bit_len[22:1]};
    wire [22:0] bit_last = bit_len - 23'h000001;
    // character length in data bits
    wire [3:0]  char_bits = nine ? 4'h9 : 4'h8;

    // ---------------------------------------------------------------
    // ahb-lite slave: zero wait states, always okay
    // ---------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    wire   acc   = hsel & hready & htrans[1];
    wire   rd_en = acc & ~hwrite;
    wire   wr_en = wr_pend_reg;
    // reading the holding byte removes the head character
    wire   pop   = rd_en & (haddr == `ADDR_HOLD);

    // read data is registered in the address phase
    reg [31:0] rd_next;
    always @* begin
        rd_next = 32'h00000000;
        if (haddr == `ADDR_RSC) begin
            rd_next[7:0] = {ctrl_reg[7:3], hold_frame_fault_flag_reg & hold_full_reg, over_reg, hold_bit9_reg};
        end else if (haddr == `ADDR_HOLD) begin
            rd_next[7:0] = hold_reg;
        end else if (haddr == `ADDR_DIV) begin
            rd_next[15:0] = div_reg;
        end else if (haddr == `ADDR_CFG) begin
            rd_next[2:0] = cfg_reg;
        end else if (haddr == `ADDR_IRQ_STAT) begin
            rd_next[2:0] = irq_stat_reg;
        end else if (haddr == `ADDR_IRQ_MASK) begin
            rd_next[2:0] = irq_mask_reg;
        end
    end

    // address phase capture and read data
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata      <= 32'h00000000;
        end else begin
            wr_pend_reg <= acc & hwrite;
            if (acc) begin
                wr_addr_reg <= haddr;
            end
            if (rd_en) begin
                hrdata <= rd_next;
            end
        end
    end

    // ---------------------------------------------------------------
    // pin synchroniser: change accepted when stages 2 and 3 agree
    // ---------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_reg     <= 3'h7;
            rx_level_reg <= 1'b1;
        end else begin
            sync_reg <= {sync_reg[1:0], rx_pin};
            if (sync_reg[1] == sync_reg[2]) begin
                rx_level_reg <= sync_reg[2];
            end
        end
    end

    // ---------------------------------------------------------------
    // receiver state machine
    // ---------------------------------------------------------------
    wire at_last  = (timer_reg == bit_last);
    wire at_half  = (timer_reg == half_len);
    wire last_bit = (bitcnt_reg == char_bits - 4'h1);
    // async stop is sampled one full bit after the last data sample, well inside the stop bit
    wire done_async = (state_reg == ST_STOP) & at_last & ~sync_mode;
    wire done_sync  = (state_reg == ST_DATA) & at_last & last_bit & sync_mode;
    wire done       = done_async | done_sync;
    // assembled character, aligned to bit 0
    wire [8:0] char_word = nine ? shift_reg : {1'b0, shift_reg[8:1]};
    // address filter only acts in 9-bit async mode
    wire keep = ~(addr_filt & nine & ~sync_mode & ~char_word[8]);
    wire frame_bad = done_async & ~rx_level_reg;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg  <= ST_IDLE;
            timer_reg  <= 23'h000000;
            bitcnt_reg <= 4'h0;
            shift_reg  <= 9'h000;
        end else if (!rx_run) begin
            // disabled port or stalled receiver sits idle
            state_reg  <= ST_IDLE;
            timer_reg  <= 23'h000000;
            bitcnt_reg <= 4'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    timer_reg  <= 23'h000000;
                    bitcnt_reg <= 4'h0;
                    if (sync_mode) begin
                        // master starts clocking immediately
                        state_reg <= ST_DATA;
                    end else if (!rx_level_reg) begin
                        state_reg <= ST_START;
                    end
                end
                ST_START: begin
                    timer_reg <= timer_reg + 23'h000001;
                    if (at_half) begin
                        // a glitch shorter than half a bit is rejected
                        timer_reg <= 23'h000000;
                        state_reg <= rx_level_reg ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    timer_reg <= at_last ? 23'h000000 : timer_reg + 23'h000001;
                    // async samples one full bit after a centre; sync at clock rise
                    if ((sync_mode & at_half) | (~sync_mode & at_last)) begin
                        shift_reg <= {rx_level_reg, shift_reg[8:1]};
                    end
                    if (at_last) begin
                        bitcnt_reg <= bitcnt_reg + 4'h1;
                        if (last_bit) begin
                            state_reg <= sync_mode ? ST_IDLE : ST_STOP;
                        end
                    end
                end
                ST_STOP: begin
                    timer_reg <= timer_reg + 23'h000001;
                    if (at_last) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // sync master clock: low first half, high second half of each bit
    assign sync_clk_oe  = port_on & sync_mode;
    assign sync_clk_out = (state_reg == ST_DATA) & sync_mode & (timer_reg >= half_len);

    // ---------------------------------------------------------------
    // holding byte, fault flags and control register
    // ---------------------------------------------------------------
    wire deliver = done & keep & ~hold_full_reg;
    // a kept character with the head still unread overflows
    wire overflow = done & keep & hold_full_reg & ~pop;
    wire wr_ctrl  = wr_en & (wr_addr_reg == `ADDR_RSC);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg      <= `RSC_RESET;
            hold_reg      <= 8'h00;
            hold_bit9_reg <= 1'b0;
            hold_frame_fault_flag_reg <= 1'b0;
            hold_full_reg <= 1'b0;
            over_reg      <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg[7:3] <= hwdata[7:3];
            end else if (done_sync & ~cont) begin
                // one-shot clears itself once its character is in
                ctrl_reg[`RSC_ONESHOT] <= 1'b0;
            end
            if (!port_on) begin
                // disabled port drops buffered data and faults
                hold_full_reg <= 1'b0;
                hold_frame_fault_flag_reg <= 1'b0;
                hold_bit9_reg <= 1'b0;
                over_reg      <= 1'b0;
            end else begin
                if (deliver | (done & keep & pop)) begin
                    hold_reg      <= char_word[7:0];
                    hold_bit9_reg <= char_word[8] & nine;
                    hold_frame_fault_flag_reg <= frame_bad;
                    hold_full_reg <= 1'b1;
                end else if (pop) begin
                    hold_full_reg <= 1'b0;
                end
                if (overflow) begin
                    over_reg <= 1'b1;
                end else if (!cont) begin
                    over_reg <= 1'b0;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // divisor, config and interrupt registers
    // ---------------------------------------------------------------
    // a character loaded in the cycle of a pop still reports its framing fault
    wire [2:0] events = {overflow, (deliver | (done & keep & pop)) & frame_bad, deliver | (done & keep & pop)};
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg      <= `DIV_RESET;
            cfg_reg      <= `CFG_RESET;
            irq_stat_reg <= `IRQ_RESET;
            irq_mask_reg <= `IRQ_RESET;
        end else begin
            if (wr_en & (wr_addr_reg == `ADDR_DIV)) begin
                div_reg <= hwdata[15:0];
            end
            if (wr_en & (wr_addr_reg == `ADDR_CFG)) begin
                cfg_reg <= hwdata[2:0];
            end
            if (wr_en & (wr_addr_reg == `ADDR_IRQ_MASK)) begin
                irq_mask_reg <= hwdata[2:0];
            end
            // a new event wins over a write-one clear in the same cycle
            if (wr_en & (wr_addr_reg == `ADDR_IRQ_STAT)) begin
                irq_stat_reg <= (irq_stat_reg & ~hwdata[2:0]) | events;
            end else begin
                irq_stat_reg <= irq_stat_reg | events;
            end
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule // uart_receive_control
`default_nettype wire

/* uart_rx_checker_asserts.sv */
// bound checker for bus answers, pin levels and interrupt gating of the receive block
`timescale 1ns/1ps
`default_nettype none
module uart_rx_checker (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus side
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // serial pins and interrupt
    input wire logic        rx_pin,
    input wire logic        sync_clk_out,
    input wire logic        sync_clk_oe,
    input wire logic        irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ------------------------------------------------------------
    // shadow of what software wrote
    // ------------------------------------------------------------
    logic       tk, rdk, rd0, rdx, oe_w; // taken phases and decodes
    logic       pv_reg;                  // write waiting for its data phase
    logic [7:0] pa_reg;                  // address of that write
    logic [4:0] ctl_reg;                 // on, nine, oneshot, cont, filter
    logic       sync_reg;                // sync mode bit
    logic [2:0] mask_reg;                // interrupt mask
    assign tk   = hsel & hready & htrans[1];
    assign rdk  = tk & !hwrite;
    assign rd0  = rdk & (haddr == 8'h00);
    assign rdx  = rdk & (haddr > 8'h14);
    assign oe_w = ctl_reg[4] & sync_reg;
    // writes land at the end of the data phase, as in the block
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pv_reg   <= 1'b0;
            pa_reg   <= 8'h00;
            ctl_reg  <= 5'h00;
            sync_reg <= 1'b0;
            mask_reg <= 3'h0;
        end else begin
            pv_reg <= tk & hwrite;
            pa_reg <= haddr;
            if (pv_reg && pa_reg == 8'h00) ctl_reg <= hwdata[7:3];
            if (pv_reg && pa_reg == 8'h0C) sync_reg <= hwdata[2];
            if (pv_reg && pa_reg == 8'h14) mask_reg <= hwdata[2:0];
        end
    end
    // ------------------------------------------------------------
    // assertions and covers
    // ------------------------------------------------------------
    a_ready_high: assert property (hreadyout) else $error("wait state inserted");
    a_resp_okay: assert property (!hresp) else $error("error response seen");
    a_clk_oe_level: assert property (oe_w == $past(oe_w) |-> sync_clk_oe == oe_w)
        else $error("sync clock enable disagrees with port and mode");
    a_clk_idle_low: assert property (!sync_clk_oe |-> !sync_clk_out)
        else $error("sync clock moves while not driven");
    a_ctl_readback: assert property (rd0 |=> hrdata[7:6] == $past(ctl_reg[4:3])
        && hrdata[4:3] == $past(ctl_reg[1:0])) else $error("control bits read back wrong");
    a_off_flags_zero: assert property (rd0 && !ctl_reg[4] && !$past(ctl_reg[4])
        |=> hrdata[2:0] == 3'h0) else $error("status flags survive port off");
    a_unmapped_zero: assert property (rdx |=> hrdata == 32'h0) else $error("unmapped read not zero");
    a_irq_masked: assert property (mask_reg == 3'h0 |-> !irq) else $error("interrupt with all masked");
    a_data_holds: assert property (!$past(rdk) |-> $stable(hrdata)) else $error("read data moved");
    c_read_ctl: cover property (rd0);
    c_irq_up: cover property ($rose(irq));
    c_sync_clk: cover property ($rose(sync_clk_out));
endmodule // uart_rx_checker
bind uart_receive_control uart_rx_checker chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_pin(rx_pin),
    .sync_clk_out(sync_clk_out), .sync_clk_oe(sync_clk_oe), .irq(irq));
`default_nettype wire

/* uart_far_tx.sv */
// remote serial transmitter model that drives the receive line
`timescale 1ns/1ps
`default_nettype none
module uart_far_tx (
    // bench clock
    input  wire logic hclk,
    // receive line of the block
    output var  logic rx_pin
);
    initial rx_pin = 1'b1; // line idles high between frames
    // ------------------------------------------------------------
    // one frame: start, data lsb first, stop, two idle bits
    // ------------------------------------------------------------
    task send(input logic [8:0] d, input int nb, input logic stp, input int bt);
        int b;
        rx_pin <= 1'b0;
        repeat (bt) @(posedge hclk);
        for (b = 0; b < nb; b++) begin
            rx_pin <= d[b];
            repeat (bt) @(posedge hclk);
        end
        rx_pin <= stp; // a low stop forces a framing fault
        repeat (bt) @(posedge hclk);
        rx_pin <= 1'b1;
        repeat (2 * bt) @(posedge hclk); // idle gives the block time to deliver
    endtask
endmodule // uart_far_tx
`default_nettype wire

/* test_uart_receive_control.sv */
// self-checking bench of the receive block against a remote transmitter model
`timescale 1ns/1ps
`default_nettype none
module test_uart_receive_control;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int BT = 8;  // divisor 1 with high and wide: 8 cycles a bit
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] rd;        // last read data
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, rx_pin, sync_clk_out, sync_clk_oe, irq;
    int          n_fail;
    int          checked;
    uart_receive_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_pin(rx_pin),
        .sync_clk_out(sync_clk_out), .sync_clk_oe(sync_clk_oe), .irq(irq));
    uart_far_tx far (.hclk(hclk), .rx_pin(rx_pin));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task end_sim;
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one bus phase; the slave never stalls, but a stuck bus must not hang us
    task phase;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 20);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            end_sim;
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        phase;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        phase;
        rd = hrdata;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // irq is combinational, so look at it mid-cycle once the edge has landed
    task irq_is(input logic e);
        @(negedge hclk);
        chk({31'h0, irq}, {31'h0, e});
        @(posedge hclk);
    endtask
    // poll the control register until the masked bits match, bounded
    task poll(input logic [31:0] m, input logic [31:0] v);
        int k;
        k = 0;
        do begin
            bus(1'b0, 8'h00, 32'h0);
            k++;
        end while ((rd & m) !== v && k < 100);
        if ((rd & m) !== v) begin
            n_fail++;
            end_sim;
        end
    endtask
    // ------------------------------------------------------------
    // clock and main sequence
    // ------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    initial begin
        n_fail = 0;
        checked = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(8'h00, 32'h0);
        rchk(8'h18, 32'h0);
        irq_is(1'b0);
        bus(1'b1, 8'h08, 32'h340);
        rchk(8'h08, 32'h340);
        bus(1'b1, 8'h08, 32'h33);
        rchk(8'h08, 32'h33);
        bus(1'b1, 8'h08, 32'h1);
        bus(1'b1, 8'h0C, 32'h3);
        bus(1'b1, 8'h00, 32'h90);
        rchk(8'h00, 32'h90);
        // 8-bit character, masked first, then unmasked and cleared
        far.send(9'h0A5, 8, 1'b1, BT);
        rchk(8'h10, 32'h1);
        irq_is(1'b0);
        bus(1'b1, 8'h14, 32'h7);
        irq_is(1'b1);
        rchk(8'h04, 32'hA5);
        rchk(8'h00, 32'h90);
        bus(1'b1, 8'h10, 32'h7);
        irq_is(1'b0);
        // 9-bit character shows its ninth bit
        bus(1'b1, 8'h00, 32'hD0);
        far.send(9'h13C, 9, 1'b1, BT);
        rchk(8'h00, 32'hD1);
        rchk(8'h04, 32'h3C);
        // address filter drops ninth-bit-clear characters
        bus(1'b1, 8'h10, 32'h7);
        bus(1'b1, 8'h00, 32'hD8);
        far.send(9'h055, 9, 1'b1, BT);
        rchk(8'h10, 32'h0);
        far.send(9'h166, 9, 1'b1, BT);
        rchk(8'h10, 32'h1);
        rchk(8'h04, 32'h66);
        // framing fault follows the head character
        bus(1'b1, 8'h10, 32'h7);
        bus(1'b1, 8'h00, 32'h90);
        far.send(9'h05A, 8, 1'b0, BT);
        rchk(8'h00, 32'h94);
        rchk(8'h10, 32'h3);
        rchk(8'h04, 32'h5A);
        rchk(8'h00, 32'h90);
        // overflow: second character lost, cleared by dropping continuous
        far.send(9'h011, 8, 1'b1, BT);
        far.send(9'h022, 8, 1'b1, BT);
        rchk(8'h00, 32'h92);
        rchk(8'h04, 32'h11);
        bus(1'b1, 8'h00, 32'h80);
        @(posedge hclk); // the flag drops one cycle after continuous receive goes low
        rchk(8'h00, 32'h80);
        // port off wipes a pending framing fault
        bus(1'b1, 8'h00, 32'h90);
        far.send(9'h033, 8, 1'b0, BT);
        bus(1'b1, 8'h00, 32'h00);
        @(posedge hclk); // the wipe follows one cycle after the port turns off
        rchk(8'h00, 32'h0);
        // slower relations: wide alone gives sixteen, neither gives sixty-four cycles per count
        bus(1'b1, 8'h0C, 32'h2);
        bus(1'b1, 8'h00, 32'h90);
        far.send(9'h0C3, 8, 1'b1, 4 * BT);
        rchk(8'h04, 32'hC3);
        bus(1'b1, 8'h0C, 32'h0);
        far.send(9'h03C, 8, 1'b1, 16 * BT);
        rchk(8'h04, 32'h3C);
        // one-shot is ignored in asynchronous mode
        bus(1'b1, 8'h10, 32'h7);
        bus(1'b1, 8'h00, 32'hA0);
        far.send(9'h077, 8, 1'b1, BT);
        rchk(8'h10, 32'h0);
        rchk(8'h00, 32'hA0);
        // sync one-shot takes one character and clears itself
        bus(1'b1, 8'h0C, 32'h6);
        poll(32'h20, 32'h0);
        chk(rd, 32'h80);
        rchk(8'h04, 32'hFF);
        // continuous overrides one-shot and runs into overflow
        bus(1'b1, 8'h00, 32'hB0);
        poll(32'h02, 32'h2);
        chk(rd, 32'hB2);
        bus(1'b1, 8'h00, 32'h00);
        end_sim;
    end
endmodule // test_uart_receive_control
`default_nettype wire
